// *** bench/sdram_bank_command_logic_tb.sv ***
`default_nettype none
module sdram_bank_command_logic_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [2:0] ACT = 3'h3;
	localparam logic [2:0] PRE = 3'h2;
	localparam logic [2:0] RD = 3'h5;
	localparam logic [2:0] WR = 3'h4;
	localparam logic [2:0] BLS [4] = '{3'h0, 3'h1, 3'h2, 3'h3};
	logic clock, rst, cs_n, ras_n, cas_n, we_n;
	logic [1:0] bank_select, byte_lane_masks, dq_oe;
	logic [11:0] address;
	logic [15:0] dq_in, dq_out;
	logic [3:0] bank_active;
	logic [2:0] mode_bl_r, mode_cl_r;
	logic [15:0] mem [4][256];
	logic [15:0] one[$] = '{16'h0};
	logic [31:0] seed_r = 32'h1;
	int err_count = 0;
	int checked = 0;
	sdram_ctrl_model i_ctrl (.clock(clock), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
		.we_n(we_n), .bank_select(bank_select), .address(address),
		.byte_lane_masks(byte_lane_masks), .dq_in(dq_in));
	sdram_bank_command_logic i_dut (.clock(clock), .rst(rst), .cs_n(cs_n), .ras_n(ras_n),
		.cas_n(cas_n), .we_n(we_n), .bank_select(bank_select), .address(address),
		.byte_lane_masks(byte_lane_masks), .dq_in(dq_in), .mode_burst_length(mode_bl_r),
		.mode_cas_latency(mode_cl_r), .mode_interleave(1'b0), .mode_single_write(1'b0),
		.dq_out(dq_out), .dq_oe(dq_oe), .bank_active(bank_active));
	// ====================
	// Helpers.
	function automatic logic [31:0] rnd();
		seed_r ^= seed_r << 13;
		seed_r ^= seed_r >> 17;
		seed_r ^= seed_r << 5;
		return seed_r;
	endfunction
	function automatic logic [7:0] wrap_of(input logic [2:0] bl);
		case (bl)
			sdram_cmd_pkg::BL_TWO: return 8'h01;
			sdram_cmd_pkg::BL_FOUR: return 8'h03;
			sdram_cmd_pkg::BL_EIGHT: return 8'h07;
			sdram_cmd_pkg::BL_FULL: return 8'hff;
			default: return 8'h00;
		endcase
	endfunction
	function automatic logic [7:0] col_at(input logic [7:0] s, input int i);
		return (s & ~wrap_of(mode_bl_r)) | ((s + 8'(i)) & wrap_of(mode_bl_r));
	endfunction
	task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t data got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cmp4(input logic [3:0] got, input logic [3:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t flags got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic setm(input logic [2:0] bl, input logic [2:0] cl);
		@(posedge clock);
		mode_bl_r <= bl;
		mode_cl_r <= cl;
		@(posedge clock);
	endtask
	// A short write leaves one more edge of released data before the interrupt lands.
	task automatic wr(input logic [1:0] b, input logic [7:0] c, input int n,
		input logic [1:0] m, input logic ap);
		logic [15:0] w[$];
		logic [7:0] k;
		for (int i = 0; i < n; i++) begin
			w.push_back(16'(rnd()));
			k = col_at(c, i);
			if (!m[0]) mem[b][k][7:0] = w[i][7:0];
			if (!m[1]) mem[b][k][15:8] = w[i][15:8];
		end
		if (n < int'(wrap_of(mode_bl_r)) + 1) mem[b][col_at(c, n)] = ~w[n-1];
		i_ctrl.send(WR, b, {1'b0, ap, 2'h0, c}, w, m);
	endtask
	task automatic chk_rd(input logic [1:0] b, input logic [7:0] c, input int n,
		input logic [1:0] m, input logic tail);
		logic [15:0] ln;
		repeat ((mode_cl_r == sdram_cmd_pkg::CL_THREE) ? 2 : 1) @(posedge clock);
		for (int i = 0; i < n; i++) begin
			@(negedge clock);
			ln = {{8{dq_oe[1]}}, {8{dq_oe[0]}}};
			cmp4({2'h0, dq_oe}, {2'h0, ((i == 0) ? ~m : 2'h3)});
			cmp16(dq_out & ln, mem[b][col_at(c, i)] & ln);
			@(posedge clock);
		end
		if (tail) begin
			@(negedge clock);
			cmp4({2'h0, dq_oe}, 4'h0);
		end
	endtask
	task automatic report_and_stop();
		$display("mismatches %0d comparisons %0d", err_count, checked);
		if (err_count == 0 && checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// ====================
	// Clock, watchdog and scenarios.
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	initial begin
		repeat (20000) @(posedge clock);
		err_count++;
		report_and_stop();
	end
	initial begin
		logic [1:0] b, m;
		logic [7:0] c;
		logic [3:0] act_e;
		int n;
		rst = 1'b1;
		mode_bl_r = sdram_cmd_pkg::BL_FOUR;
		mode_cl_r = sdram_cmd_pkg::CL_TWO;
		act_e = 4'h0;
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		cmp4(bank_active, act_e);
		for (int i = 0; i < 4; i++) begin
			i_ctrl.send(ACT, 2'(i), 12'(rnd()), one, 2'h0);
			act_e[i] = 1'b1;
			@(negedge clock);
			cmp4(bank_active, act_e);
		end
		for (int i = 0; i < 8; i++) begin
			setm(BLS[i % 4], (i < 4) ? sdram_cmd_pkg::CL_TWO : sdram_cmd_pkg::CL_THREE);
			b = 2'(rnd());
			c = 8'(rnd());
			m = (i < 4) ? 2'(rnd()) : 2'h0;
			n = int'(wrap_of(mode_bl_r)) + 1;
			wr(b, c, n, 2'h0, 1'b0);
			wr(b, c, n, 2'(rnd()), 1'b0);
			i_ctrl.send(RD, b, {4'h0, c}, one, m);
			chk_rd(b, c, n, m, 1'b1);
		end
		setm(sdram_cmd_pkg::BL_EIGHT, sdram_cmd_pkg::CL_TWO);
		i_ctrl.send(RD, b, {4'h0, c}, one, 2'h0);
		fork
			chk_rd(b, c, 2, 2'h0, 1'b0);
			begin
				i_ctrl.send(RD, b, {4'h0, c ^ 8'h04}, one, 2'h0);
				chk_rd(b, c ^ 8'h04, 8, 2'h0, 1'b1);
			end
		join
		wr(b, c, 2, 2'h0, 1'b0);
		i_ctrl.send(RD, b, {4'h0, c}, one, 2'h0);
		chk_rd(b, c, 8, 2'h0, 1'b1);
		setm(sdram_cmd_pkg::BL_FULL, sdram_cmd_pkg::CL_TWO);
		wr(b, 8'hff, 2, 2'h0, 1'b0);
		i_ctrl.send(PRE, b, 12'h000, one, 2'h0);
		act_e[b] = 1'b0;
		@(negedge clock);
		cmp4(bank_active, act_e);
		i_ctrl.send(ACT, b, 12'(rnd()), one, 2'h0);
		i_ctrl.send(RD, b, 12'h0ff, one, 2'h0);
		fork
			chk_rd(b, 8'hff, 3, 2'h0, 1'b0);
			begin
				repeat (3) @(posedge clock);
				i_ctrl.send(PRE, b, 12'h000, one, 2'h0);
			end
		join
		setm(sdram_cmd_pkg::BL_FOUR, sdram_cmd_pkg::CL_TWO);
		repeat (4) @(posedge clock);
		i_ctrl.send(ACT, b, 12'h000, one, 2'h0);
		wr(b, c, 4, 2'h0, 1'b1);
		@(negedge clock);
		cmp4(bank_active, act_e);
		i_ctrl.send(ACT, b, 12'h000, one, 2'h0);
		i_ctrl.send(RD, b, {4'h4, c}, one, 2'h0);
		chk_rd(b, c, 4, 2'h0, 1'b1);
		cmp4(bank_active, act_e);
		i_ctrl.send(PRE, 2'(rnd()), 12'h400, one, 2'h0);
		@(negedge clock);
		cmp4(bank_active, 4'h0);
		report_and_stop();
	end
endmodule
`default_nettype wire

// *** bench/sdram_ctrl_model.sv ***
`default_nettype none
// ====================
// Memory controller model: every change leaves just after a rising edge.
module sdram_ctrl_model (
	input wire logic clock,
	output logic cs_n,
	output logic ras_n,
	output logic cas_n,
	output logic we_n,
	output logic [sdram_cmd_pkg::BANK_W-1:0] bank_select,
	output logic [sdram_cmd_pkg::ROW_W-1:0] address,
	output logic [sdram_cmd_pkg::LANES-1:0] byte_lane_masks,
	output logic [sdram_cmd_pkg::DATA_W-1:0] dq_in
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		cs_n = 1'b1;
		{ras_n, cas_n, we_n} = 3'h7;
		bank_select = '0;
		address = '0;
		byte_lane_masks = '0;
		dq_in = '0;
	end
	// Timing between commands is the caller's business, so the model stays simple.
	// The caller never lets a write cut into a read, so no mask lead is needed.
	task automatic send(input logic [2:0] op, input logic [1:0] b, input logic [11:0] a,
		input logic [15:0] w[$], input logic [1:0] m);
		@(posedge clock);
		cs_n <= 1'b0;
		{ras_n, cas_n, we_n} <= op;
		bank_select <= b;
		address <= a;
		byte_lane_masks <= m;
		dq_in <= w[0];
		for (int i = 1; i < w.size(); i++) begin
			@(posedge clock);
			cs_n <= 1'b1;
			dq_in <= w[i];
		end
		// Released bank, address and data lines show inverted values so stale data cannot pass for a hold.
		@(posedge clock);
		cs_n <= 1'b1;
		{ras_n, cas_n, we_n} <= 3'h7;
		bank_select <= ~b;
		address <= ~a;
		byte_lane_masks <= 2'h0;
		dq_in <= ~w[w.size()-1];
	endtask
endmodule
`default_nettype wire

// *** rtl/sdram_bank_command_logic.sv ***
// Notes on behaviour
// - Activate opens idle bank, latches row.
// - Bank precharge returns selected bank to idle.
// - Precharge-all idles every bank at once.
// - Read data after CAS latency, then consecutive.
// - Data pins float when read burst ends.
// - Full page bursts run on, wrapping columns.
// - Read output gated by mask two clocks earlier.
// - Read burst cut by read, write, precharge.
// - Read auto precharge closes bank after burst.
// - Write captures first word with the command.
// - Write burst cut by write, read, precharge.
// - Read over write drops remaining write data.
// - Write auto precharge closes bank after burst.
// - CAS latency is two or three clocks.
// - Burst length is 1, 2, 4, 8 or page.
`default_nettype none

module sdram_bank_command_logic (
	input wire logic clock,
	input wire logic rst,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [sdram_cmd_pkg::BANK_W-1:0] bank_select,
	input wire logic [sdram_cmd_pkg::ROW_W-1:0] address,
	input wire logic [sdram_cmd_pkg::LANES-1:0] byte_lane_masks,
	input wire logic [sdram_cmd_pkg::DATA_W-1:0] dq_in,
	input wire logic [2:0] mode_burst_length,
	input wire logic [2:0] mode_cas_latency,
	input wire logic mode_interleave,
	input wire logic mode_single_write,
	output logic [sdram_cmd_pkg::DATA_W-1:0] dq_out,
	output logic [sdram_cmd_pkg::LANES-1:0] dq_oe,
	output logic [sdram_cmd_pkg::BANKS-1:0] bank_active
);

	// ========================================================
	// Command decode
	logic cmd_act;
	logic cmd_pre;
	logic cmd_rd;
	logic cmd_wr;
	logic col_ok;
	assign cmd_act = !cs_n && !ras_n && cas_n && we_n;
	assign cmd_pre = !cs_n && !ras_n && cas_n && !we_n;
	assign cmd_rd = !cs_n && ras_n && !cas_n && we_n;
	assign cmd_wr = !cs_n && ras_n && !cas_n && !we_n;

	// ========================================================
	// State
	sdram_cmd_pkg::burst_type state_r, state_nxt;
	logic [sdram_cmd_pkg::BANKS-1:0] open_r, open_nxt;
	logic [sdram_cmd_pkg::ROW_W-1:0] row_r [sdram_cmd_pkg::BANKS];
	logic [sdram_cmd_pkg::ROW_W-1:0] row_nxt [sdram_cmd_pkg::BANKS];
	logic [sdram_cmd_pkg::BANK_W-1:0] bank_r, bank_nxt;
	logic [sdram_cmd_pkg::COL_W-1:0] start_r, start_nxt;
	logic [sdram_cmd_pkg::COL_W-1:0] cnt_r, cnt_nxt;
	logic [sdram_cmd_pkg::COL_W-1:0] wrap_r, wrap_nxt;
	logic auto_r, auto_nxt;
	logic full_r, full_nxt;
	logic [sdram_cmd_pkg::DATA_W-1:0] pipe_r, pipe_nxt;
	logic pipe_valid_r, pipe_valid_nxt;
	logic [sdram_cmd_pkg::DATA_W-1:0] out_r, out_nxt;
	logic out_valid_r, out_valid_nxt;
	logic [sdram_cmd_pkg::LANES-1:0] oe_r, oe_nxt;
	logic [sdram_cmd_pkg::LANES-1:0] mask_r;

	// Column commands only count when their bank is open.
	assign col_ok = open_r[bank_select];

	// Storage holds one page per bank; the row address is tracked but not decoded.
	logic [sdram_cmd_pkg::DATA_W-1:0] mem_r [sdram_cmd_pkg::BANKS*256];
	logic mem_we;
	logic [sdram_cmd_pkg::BANK_W+sdram_cmd_pkg::COL_W-1:0] mem_idx;
	logic [sdram_cmd_pkg::DATA_W-1:0] fetch_data;
	logic fetch_valid;
	logic [sdram_cmd_pkg::COL_W-1:0] cur_col;
	logic [sdram_cmd_pkg::COL_W-1:0] new_wrap;
	logic last_word;
	logic cas_three;

	assign dq_out = out_r;
	assign dq_oe = oe_r;
	assign bank_active = open_r;
	assign cas_three = (mode_cas_latency == sdram_cmd_pkg::CL_THREE);

	// ========================================================
	// Burst addressing
	always_comb begin
		unique case (mode_burst_length)
			sdram_cmd_pkg::BL_TWO: new_wrap = sdram_cmd_pkg::WRAP_TWO;
			sdram_cmd_pkg::BL_FOUR: new_wrap = sdram_cmd_pkg::WRAP_FOUR;
			sdram_cmd_pkg::BL_EIGHT: new_wrap = sdram_cmd_pkg::WRAP_EIGHT;
			sdram_cmd_pkg::BL_FULL: new_wrap = sdram_cmd_pkg::WRAP_FULL;
			default: new_wrap = sdram_cmd_pkg::WRAP_ONE;
		endcase
		// Page bursts only support sequential order, so interleave is dropped there.
		if (mode_interleave && !full_r) begin
			cur_col = (start_r & ~wrap_r) | ((start_r ^ cnt_r) & wrap_r);
		end else begin
			cur_col = (start_r & ~wrap_r) | (8'(start_r + cnt_r) & wrap_r);
		end
		last_word = !full_r && (cnt_r == wrap_r);
	end

	// ========================================================
	// Bank and burst control
	always_comb begin
		state_nxt = state_r;
		open_nxt = open_r;
		row_nxt = row_r;
		bank_nxt = bank_r;
		start_nxt = start_r;
		cnt_nxt = cnt_r;
		wrap_nxt = wrap_r;
		auto_nxt = auto_r;
		full_nxt = full_r;
		mem_we = 1'b0;
		mem_idx = {bank_r, cur_col};
		fetch_valid = 1'b0;
		unique case (state_r)
			sdram_cmd_pkg::burst_idle: begin
			end
			sdram_cmd_pkg::burst_read: begin
				fetch_valid = 1'b1;
				cnt_nxt = 8'(cnt_r + 8'h01);
				if (last_word) begin
					state_nxt = sdram_cmd_pkg::burst_idle;
					if (auto_r) begin
						open_nxt[bank_r] = 1'b0;
					end
				end
			end
			sdram_cmd_pkg::burst_write: begin
				mem_we = 1'b1;
				cnt_nxt = 8'(cnt_r + 8'h01);
				if (last_word) begin
					state_nxt = sdram_cmd_pkg::burst_idle;
					if (auto_r) begin
						open_nxt[bank_r] = 1'b0;
					end
				end
			end
		endcase
		if (cmd_act && !open_r[bank_select]) begin
			open_nxt[bank_select] = 1'b1;
			row_nxt[bank_select] = address;
		end
		if (cmd_pre) begin
			if (address[sdram_cmd_pkg::AUTO_PRE_BIT]) begin
				open_nxt = sdram_cmd_pkg::OPEN_RESET;
			end else begin
				open_nxt[bank_select] = 1'b0;
			end
			if (address[sdram_cmd_pkg::AUTO_PRE_BIT] || bank_select == bank_r) begin
				state_nxt = sdram_cmd_pkg::burst_idle;
				mem_we = 1'b0;
			end
		end
		if ((cmd_rd || cmd_wr) && col_ok) begin
			// A new column command replaces any running burst at once.
			bank_nxt = bank_select;
			start_nxt = address[sdram_cmd_pkg::COL_W-1:0];
			full_nxt = (mode_burst_length == sdram_cmd_pkg::BL_FULL);
			auto_nxt = address[sdram_cmd_pkg::AUTO_PRE_BIT] && !full_nxt;
			cnt_nxt = sdram_cmd_pkg::COL_RESET;
			wrap_nxt = new_wrap;
			mem_we = 1'b0;
			if (cmd_rd) begin
				state_nxt = sdram_cmd_pkg::burst_read;
			end else begin
				mem_we = 1'b1;
				mem_idx = {bank_select, address[sdram_cmd_pkg::COL_W-1:0]};
				if (mode_single_write) begin
					wrap_nxt = sdram_cmd_pkg::WRAP_ONE;
					full_nxt = 1'b0;
				end
				if (mode_single_write || new_wrap == sdram_cmd_pkg::WRAP_ONE) begin
					state_nxt = sdram_cmd_pkg::burst_idle;
					if (auto_nxt) begin
						open_nxt[bank_select] = 1'b0;
					end
				end else begin
					state_nxt = sdram_cmd_pkg::burst_write;
					cnt_nxt = 8'h01;
				end
			end
		end
	end

	// ========================================================
	// Read output pipe
	always_comb begin
		fetch_data = mem_r[{bank_r, cur_col}];
		pipe_nxt = fetch_data;
		pipe_valid_nxt = fetch_valid;
		// Only latency two and three exist; reserved codes behave as two.
		out_nxt = cas_three ? pipe_r : fetch_data;
		out_valid_nxt = cas_three ? pipe_valid_r : fetch_valid;
		// Lanes float whenever no word is due, so the bus is free after a burst.
		oe_nxt = {sdram_cmd_pkg::LANES{out_valid_nxt}} & ~mask_r;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_r <= sdram_cmd_pkg::burst_idle;
			open_r <= sdram_cmd_pkg::OPEN_RESET;
			for (int i = 0; i < sdram_cmd_pkg::BANKS; i++) begin
				row_r[i] <= 12'h000;
			end
			bank_r <= 2'h0;
			start_r <= sdram_cmd_pkg::COL_RESET;
			cnt_r <= sdram_cmd_pkg::COL_RESET;
			wrap_r <= sdram_cmd_pkg::WRAP_ONE;
			auto_r <= 1'b0;
			full_r <= 1'b0;
			pipe_r <= 16'h0000;
			pipe_valid_r <= 1'b0;
			out_r <= 16'h0000;
			out_valid_r <= 1'b0;
			oe_r <= 2'h0;
			mask_r <= 2'h3;
		end else begin
			state_r <= state_nxt;
			open_r <= open_nxt;
			row_r <= row_nxt;
			bank_r <= bank_nxt;
			start_r <= start_nxt;
			cnt_r <= cnt_nxt;
			wrap_r <= wrap_nxt;
			auto_r <= auto_nxt;
			full_r <= full_nxt;
			pipe_r <= pipe_nxt;
			pipe_valid_r <= pipe_valid_nxt;
			out_r <= out_nxt;
			out_valid_r <= out_valid_nxt;
			oe_r <= oe_nxt;
			mask_r <= byte_lane_masks;
		end
	end

	// Storage has no reset; write masks act on the same edge as the data.
	always_ff @(posedge clock) begin
		if (mem_we) begin
			for (int l = 0; l < sdram_cmd_pkg::LANES; l++) begin
				if (!byte_lane_masks[l]) begin
					mem_r[mem_idx][l*8 +: 8] <= dq_in[l*8 +: 8];
				end
			end
		end
	end

	// ========================================================
	// Checks
	chk_act_opens_bank: assert property (
		@(posedge clock) disable iff (rst)
		(cmd_act && !open_r[bank_select]) |=> (open_r[$past(bank_select)]
			&& row_r[$past(bank_select)] == $past(address)))
		else $error("Activate did not open the bank.");

	chk_pre_closes_bank: assert property (
		@(posedge clock) disable iff (rst)
		(cmd_pre && !address[sdram_cmd_pkg::AUTO_PRE_BIT]) |=> !open_r[$past(bank_select)])
		else $error("Precharge left the bank open.");

	chk_pre_all_idle: assert property (
		@(posedge clock) disable iff (rst)
		(cmd_pre && address[sdram_cmd_pkg::AUTO_PRE_BIT]) |=> (open_r == 4'h0))
		else $error("Precharge-all left a bank open.");

	chk_cas_two_data: assert property (
		@(posedge clock) disable iff (rst)
		(cmd_rd && col_ok && !cas_three && byte_lane_masks == 2'h0)
			##1 (!cs_n == 1'b0 && byte_lane_masks == 2'h0) |=> (dq_oe == 2'h3))
		else $error("Read data missing at latency two.");

	chk_cas_three_data: assert property (
		@(posedge clock) disable iff (rst)
		(cmd_rd && col_ok && cas_three) ##1 (cs_n && cas_three)
			|=> (dq_oe == 2'h0) ##1 (out_valid_r == 1'b1))
		else $error("Read data timing wrong at latency three.");

	chk_float_after: assert property (
		@(posedge clock) disable iff (rst)
		(!fetch_valid && !pipe_valid_r) |=> (dq_oe == 2'h0))
		else $error("Data pins driven with no word due.");

	chk_mask_gates_read: assert property (
		@(posedge clock) disable iff (rst)
		byte_lane_masks[0] |-> ##2 !dq_oe[0])
		else $error("Masked read lane was driven.");

	chk_write_first_word: assert property (
		@(posedge clock) disable iff (rst)
		(cmd_wr && col_ok && byte_lane_masks == 2'h0) |=>
			(mem_r[{$past(bank_select), $past(address[7:0])}] == $past(dq_in)))
		else $error("Write did not capture its first word.");

	chk_read_stops_write: assert property (
		@(posedge clock) disable iff (rst)
		(state_r == sdram_cmd_pkg::burst_write && cmd_rd && col_ok)
			|=> (state_r == sdram_cmd_pkg::burst_read && !mem_we))
		else $error("Write burst continued after a read.");

	chk_page_runs_on: assert property (
		@(posedge clock) disable iff (rst)
		(state_r != sdram_cmd_pkg::burst_idle && full_r && cs_n)
			|=> (state_r == $past(state_r) && cnt_r == 8'($past(cnt_r) + 8'h01)))
		else $error("Page burst stopped on its own.");

	chk_auto_close: assert property (
		@(posedge clock) disable iff (rst)
		(state_r == sdram_cmd_pkg::burst_read && auto_r && last_word && cs_n)
			|=> !open_r[$past(bank_r)])
		else $error("Auto precharge did not close the bank.");

endmodule

`default_nettype wire

// *** rtl/sdram_cmd_pkg.sv ***
`default_nettype none

package sdram_cmd_pkg;

	// ========================================================
	// Array shape
	localparam int BANK_W = 2;
	localparam int BANKS = 4;
	localparam int ROW_W = 12;
	localparam int COL_W = 8;
	localparam int DATA_W = 16;
	localparam int LANES = 2;

	// ========================================================
	// Address field positions
	localparam int AUTO_PRE_BIT = 10;

	// ========================================================
	// Burst length codes and the column wrap mask each one implies
	localparam logic [2:0] BL_ONE = 3'h0;
	localparam logic [2:0] BL_TWO = 3'h1;
	localparam logic [2:0] BL_FOUR = 3'h2;
	localparam logic [2:0] BL_EIGHT = 3'h3;
	localparam logic [2:0] BL_FULL = 3'h7;
	localparam logic [7:0] WRAP_ONE = 8'h00;
	localparam logic [7:0] WRAP_TWO = 8'h01;
	localparam logic [7:0] WRAP_FOUR = 8'h03;
	localparam logic [7:0] WRAP_EIGHT = 8'h07;
	localparam logic [7:0] WRAP_FULL = 8'hff;

	// ========================================================
	// CAS latency codes, in clocks from read command to first data
	localparam logic [2:0] CL_TWO = 3'h2;
	localparam logic [2:0] CL_THREE = 3'h3;

	// ========================================================
	// Reset values
	localparam logic [BANKS-1:0] OPEN_RESET = 4'h0;
	localparam logic [COL_W-1:0] COL_RESET = 8'h00;

	typedef enum logic [1:0] {
		burst_idle,
		burst_read,
		burst_write
	} burst_type;

endpackage

`default_nettype wire
